/* File: core/map_dec_consts.svh */
// Address map, field positions and reset values of the local-to-VME map decoders
`ifndef MAP_DEC_CONSTS_SVH
`define MAP_DEC_CONSTS_SVH

// Register word addresses on the local bus
`define MD_ADDR_SEG1     32'hfff40014
`define MD_ADDR_SEG2     32'hfff40018
`define MD_ADDR_SEG3     32'hfff4001c
`define MD_ADDR_SEG4     32'hfff40020
`define MD_ADDR_XLATE4   32'hfff40024
`define MD_ADDR_ATTR     32'hfff40028
`define MD_ADDR_ENABLE   32'hfff4002c

// Word index into the register array
`define MD_IDX_W         3
`define MD_IDX_XLATE     3'h4
`define MD_IDX_ATTR      3'h5
`define MD_IDX_ENABLE    3'h6
`define MD_IDX_NONE      3'h7
`define MD_NUM_WORDS     6

// Address halves
`define MD_HI_MSB        31
`define MD_HI_LSB        16
`define MD_LO_MSB        15
`define MD_LO_LSB        0

// Attribute byte layout
`define MD_ATTR_W        8
`define MD_ATTR_D16_BIT  7
`define MD_ATTR_WP_BIT   6
`define MD_ATTR_AM_MSB   5
`define MD_ATTR_AM_LSB   0

// Decoder enable bits in the enable control word
`define MD_EN_MSB        19
`define MD_EN_LSB        16
`define MD_NUM_SEG       4

// Reset values
`define MD_RST_WORD      32'h0000_0000
`define MD_RST_EN        4'h0

`endif

/* File: core/map_dec_pkg.sv */
// Types shared by the local-to-VME map decoder files
package map_dec_pkg;

	typedef logic [15:0] seg_addr_t;
	typedef logic [7:0]  attr_byte_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_VME
	} xfer_state_t;

endpackage

/* File: core/segment_match.sv */
// Range match of one programmable local-to-VME segment
`timescale 1ns/1ps

module segment_match (
	// Segment programming
	input  wire map_dec_pkg::seg_addr_t seg_start,
	input  wire map_dec_pkg::seg_addr_t seg_end,
	input  wire logic                   seg_enable,
	// Upper half of the local access address
	input  wire map_dec_pkg::seg_addr_t addr_hi,
	// Match result
	output logic                        seg_hit
);

	// 64KB granularity: only the upper 16 address bits are compared
	wire ge_start;
	wire le_end;

	assign ge_start = (addr_hi >= seg_start);
	assign le_end   = (addr_hi <= seg_end);
	assign seg_hit  = seg_enable & ge_start & le_end;

endmodule // segment_match

/* File: core/local_to_vme_map_decoders.sv */
// Programmable local-bus-to-VMEbus map decoders with their register file
`timescale 1ns/1ps
`include "map_dec_consts.svh"

// Operation
// R1 - Segment three start value sits in bits 15:0 at 0xfff4001c, RW, reset zero.
// R2 - Segment four end value sits in bits 31:16 at 0xfff40020, RW, reset zero.
// R3 - Segment four start value sits in bits 15:0 of that word, RW, reset zero.
// R4 - Segment four translation value sits in bits 31:16 at 0xfff40024, reset zero.
// R5 - Segment four translation mask sits in bits 15:0 there, reset zero.
// R6 - Segment four attribute byte is bits 31:24: width, post, modifier code.
// R7 - Segment three attribute byte is bits 23:16: width, post, modifier code.
// R8 - Segment two attribute byte is bits 15:8: width, post, modifier code.
// R9 - Segment one attribute byte is bits 7:0: width, post, modifier code.
// R10 - A VME cycle in a segment drives that segment's six-bit modifier code.
// R11 - Writes are posted only when the segment's post bit is one.
// R12 - Width bit one gives 16-bit transfers, zero gives 32-bit transfers.
// R13 - Software never loads block-transfer modifier codes; the bridge has none.
// R14 - Segment four upper address bits come from translation value where mask is set.
// R15 - Segments span 64KB steps from 64KB to 4GB via 16-bit bounds.
// R16 - A decoder answers only while its enable bit, bits 19:16 at 0xfff4002c, is set.
// R17 - An enabled decoder claims addresses within start..end and launches a VME cycle.
module local_to_vme_map_decoders (
	// Clock and reset
	input  wire  logic        mclk,
	input  wire  logic        rst,
	// Register access port
	input  wire  logic        reg_sel,
	input  wire  logic        reg_wr,
	input  wire  logic [31:0] reg_addr,
	input  wire  logic [3:0]  reg_be,
	input  wire  logic [31:0] reg_wdata,
	output logic              reg_ack,
	output logic       [31:0] reg_rdata,
	// Local bus access to be mapped onto VMEbus
	input  wire  logic        acc_req,
	input  wire  logic        acc_write,
	input  wire  logic [31:0] acc_addr,
	input  wire  logic [31:0] acc_wdata,
	output logic              acc_claim,
	output logic              acc_ack,
	output logic       [31:0] acc_rdata,
	// VMEbus master cycle request
	output logic              vme_req,
	output logic              vme_write,
	output logic       [31:0] vme_addr,
	output logic       [5:0]  vme_am,
	output logic              vme_narrow_width_select,
	output logic       [31:0] vme_wdata,
	input  wire  logic        vme_done,
	input  wire  logic [31:0] vme_rdata
);

	// Register word address to array index
	function automatic logic [`MD_IDX_W-1:0] word_index(input logic [31:0] a);
		case (a)
			`MD_ADDR_SEG1:   word_index = `MD_IDX_W'(0);
			`MD_ADDR_SEG2:   word_index = `MD_IDX_W'(1);
			`MD_ADDR_SEG3:   word_index = `MD_IDX_W'(2);
			`MD_ADDR_SEG4:   word_index = `MD_IDX_W'(3);
			`MD_ADDR_XLATE4: word_index = `MD_IDX_XLATE;
			`MD_ADDR_ATTR:   word_index = `MD_IDX_ATTR;
			`MD_ADDR_ENABLE: word_index = `MD_IDX_ENABLE;
			default:         word_index = `MD_IDX_NONE;
		endcase
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] m;
		m = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		lane_merge = m;
	endfunction

	// Write strobe of one register word
	function automatic logic word_write(input logic wr, input logic [`MD_IDX_W-1:0] idx,
		input logic [`MD_IDX_W-1:0] sel);
		word_write = wr && (idx == sel);
	endfunction

	// Register storage
	logic [31:0] word_ff [`MD_NUM_WORDS];
	logic [31:0] nxt_word [`MD_NUM_WORDS];
	logic [`MD_NUM_SEG-1:0] enable_ff;
	logic [`MD_NUM_SEG-1:0] nxt_enable;
	logic        reg_ack_ff;
	logic [31:0] reg_rdata_ff;
	logic [31:0] nxt_reg_rdata;

	// Register access decode
	wire                  reg_take;
	wire [`MD_IDX_W-1:0]  reg_idx;
	wire                  reg_write;
	wire [31:0]           enable_word;
	wire [31:0]           merged_enable;

	assign reg_take      = reg_sel & ~reg_ack_ff;
	assign reg_idx       = word_index(reg_addr);
	assign reg_write     = reg_take & reg_wr;
	assign enable_word   = {12'h000, enable_ff, 16'h0000};
	assign merged_enable = lane_merge(enable_word, reg_wdata, reg_be);

	// Per-word write with byte enables; all words clear on reset
	generate
		for (genvar w = 0; w < `MD_NUM_WORDS; w++) begin : g_word
			assign nxt_word[w] = word_write(reg_write, reg_idx, `MD_IDX_W'(w)) ?
				lane_merge(word_ff[w], reg_wdata, reg_be) : word_ff[w];
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					word_ff[w] <= `MD_RST_WORD; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9]
				end else begin
					word_ff[w] <= nxt_word[w];
				end
			end
		end
	endgenerate

	// Only the four enable bits of this word are stored; the rest reads as zero
	assign nxt_enable = word_write(reg_write, reg_idx, `MD_IDX_ENABLE) ?
		merged_enable[`MD_EN_MSB:`MD_EN_LSB] : enable_ff; // [R16]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enable_ff <= `MD_RST_EN; // [R16]
		end else begin
			enable_ff <= nxt_enable;
		end
	end

	// Read mux: unmapped addresses and unused bits read as zero
	always_comb begin
		nxt_reg_rdata = reg_rdata_ff;
		if (reg_take && !reg_wr) begin
			if (reg_idx == `MD_IDX_ENABLE) begin
				nxt_reg_rdata = enable_word;
			end else if (reg_idx == `MD_IDX_NONE) begin
				nxt_reg_rdata = `MD_RST_WORD;
			end else begin
				nxt_reg_rdata = word_ff[reg_idx];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_ack_ff   <= 1'b0;
			reg_rdata_ff <= `MD_RST_WORD;
		end else begin
			reg_ack_ff   <= reg_take;
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	assign reg_ack   = reg_ack_ff;
	assign reg_rdata = reg_rdata_ff;

	// Field views of the programmed segments
	map_dec_pkg::seg_addr_t  seg_start [`MD_NUM_SEG];
	map_dec_pkg::seg_addr_t  seg_end   [`MD_NUM_SEG];
	map_dec_pkg::attr_byte_t seg_attr  [`MD_NUM_SEG];
	logic [`MD_NUM_SEG-1:0]  seg_hit;

	generate
		for (genvar s = 0; s < `MD_NUM_SEG; s++) begin : g_seg
			assign seg_start[s] = word_ff[s][`MD_LO_MSB:`MD_LO_LSB]; // [R1] [R3]
			assign seg_end[s]   = word_ff[s][`MD_HI_MSB:`MD_HI_LSB]; // [R2]
			assign seg_attr[s]  =
				word_ff[`MD_IDX_ATTR][s*`MD_ATTR_W +: `MD_ATTR_W]; // [R6] [R7] [R8] [R9]

			segment_match u_match (
				.seg_start  (seg_start[s]),
				.seg_end    (seg_end[s]),
				.seg_enable (enable_ff[s]),
				.addr_hi    (acc_addr[`MD_HI_MSB:`MD_HI_LSB]),
				.seg_hit    (seg_hit[s])
			); // [R15] [R16] [R17]
		end
	endgenerate

	// Lowest-numbered segment wins if software lets them overlap
	// Overlap is a programming error; the fixed priority only keeps the choice stable
	logic [1:0] hit_sel;

	always_comb begin
		hit_sel = 2'd0;
		for (int s = `MD_NUM_SEG - 1; s >= 0; s--) begin
			if (seg_hit[s]) begin
				hit_sel = 2'(s);
			end
		end
	end

	wire                     any_hit;
	map_dec_pkg::attr_byte_t hit_attr;
	wire                     hit_post;
	wire                     hit_narrow;
	wire [5:0]               hit_am;
	wire [15:0]              xlate_value;
	wire [15:0]              xlate_mask;
	wire [15:0]              xlate_hi;
	wire [31:0]              hit_addr;
	wire                     hit_seg4;

	assign any_hit    = |seg_hit; // [R17]
	assign hit_seg4   = (hit_sel == 2'd3);
	assign hit_attr   = seg_attr[hit_sel];
	assign hit_post   = hit_attr[`MD_ATTR_WP_BIT]; // [R11]
	assign hit_narrow = hit_attr[`MD_ATTR_D16_BIT]; // [R12]
	assign hit_am     = hit_attr[`MD_ATTR_AM_MSB:`MD_ATTR_AM_LSB]; // [R10] [R13]

	// Segment four address translation on the upper half only
	assign xlate_value = word_ff[`MD_IDX_XLATE][`MD_HI_MSB:`MD_HI_LSB]; // [R4]
	assign xlate_mask  = word_ff[`MD_IDX_XLATE][`MD_LO_MSB:`MD_LO_LSB]; // [R5]
	assign xlate_hi    = (xlate_value & xlate_mask) |
		(acc_addr[`MD_HI_MSB:`MD_HI_LSB] & ~xlate_mask); // [R14]
	assign hit_addr    = hit_seg4 ?
		{xlate_hi, acc_addr[`MD_LO_MSB:`MD_LO_LSB]} : acc_addr; // [R14]

	// Transfer sequencer
	map_dec_pkg::xfer_state_t state_ff;
	map_dec_pkg::xfer_state_t nxt_state;
	logic        acc_ack_ff;
	logic        nxt_acc_ack;
	logic        posted_ff;
	logic        nxt_posted;
	logic        vme_write_ff;
	logic [31:0] vme_addr_ff;
	logic [5:0]  vme_am_ff;
	logic        vme_narrow_ff;
	logic [31:0] vme_wdata_ff;
	logic [31:0] acc_rdata_ff;

	wire in_idle;
	wire vme_end;
	wire rd_capture;
	wire launch;
	wire post_now;

	// Sequencer decodes shared by the state logic and the capture registers
	assign in_idle    = (state_ff == map_dec_pkg::ST_IDLE);
	assign vme_end    = (state_ff == map_dec_pkg::ST_VME) & vme_done;
	assign rd_capture = vme_end & ~vme_write_ff;

	// A posted write is acknowledged at launch; later requests wait for idle
	// The ack blocks a relaunch while the requester still holds its request
	assign launch   = in_idle & acc_req & any_hit & ~acc_ack_ff;
	assign post_now = launch & acc_write & hit_post; // [R11]

	always_comb begin
		nxt_state   = state_ff;
		nxt_acc_ack = 1'b0;
		nxt_posted  = posted_ff;
		case (state_ff)
			map_dec_pkg::ST_IDLE: begin
				if (launch) begin
					nxt_state   = map_dec_pkg::ST_VME; // [R17]
					nxt_acc_ack = post_now; // [R11]
					nxt_posted  = post_now;
				end
			end
			map_dec_pkg::ST_VME: begin
				if (vme_done) begin
					nxt_state   = map_dec_pkg::ST_IDLE;
					nxt_acc_ack = ~posted_ff; // [R11]
					nxt_posted  = 1'b0;
				end
			end
			default: begin
				nxt_state  = map_dec_pkg::ST_IDLE;
				nxt_posted = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff   <= map_dec_pkg::ST_IDLE;
			acc_ack_ff <= 1'b0;
			posted_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			acc_ack_ff <= nxt_acc_ack;
			posted_ff  <= nxt_posted;
		end
	end

	// Cycle attributes are frozen at launch for the whole VME cycle
	// A posted write cannot report a far-side failure back to the local master
	logic        nxt_vme_write;
	logic [31:0] nxt_vme_addr;
	logic [5:0]  nxt_vme_am;
	logic        nxt_vme_narrow;
	logic [31:0] nxt_vme_wdata;
	logic [31:0] nxt_acc_rdata;

	assign nxt_vme_write  = launch ? acc_write : vme_write_ff;
	assign nxt_vme_addr   = launch ? hit_addr : vme_addr_ff; // [R14]
	assign nxt_vme_am     = launch ? hit_am : vme_am_ff; // [R10]
	assign nxt_vme_narrow = launch ? hit_narrow : vme_narrow_ff; // [R12]
	assign nxt_vme_wdata  = launch ? acc_wdata : vme_wdata_ff;
	assign nxt_acc_rdata  = rd_capture ? vme_rdata : acc_rdata_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			vme_write_ff  <= 1'b0;
			vme_addr_ff   <= `MD_RST_WORD;
			vme_am_ff     <= 6'h00;
			vme_narrow_ff <= 1'b0;
			vme_wdata_ff  <= `MD_RST_WORD;
		end else begin
			vme_write_ff  <= nxt_vme_write;
			vme_addr_ff   <= nxt_vme_addr;
			vme_am_ff     <= nxt_vme_am;
			vme_narrow_ff <= nxt_vme_narrow;
			vme_wdata_ff  <= nxt_vme_wdata;
		end
	end

	// Read data returned to the local master when the VME cycle ends
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc_rdata_ff <= `MD_RST_WORD;
		end else begin
			acc_rdata_ff <= nxt_acc_rdata;
		end
	end

	assign acc_claim               = acc_req & any_hit; // [R16] [R17]
	assign acc_ack                 = acc_ack_ff;
	assign acc_rdata               = acc_rdata_ff;
	assign vme_req                 = (state_ff == map_dec_pkg::ST_VME);
	assign vme_write               = vme_write_ff;
	assign vme_addr                = vme_addr_ff;
	assign vme_am                  = vme_am_ff;
	assign vme_narrow_width_select = vme_narrow_ff;
	assign vme_wdata               = vme_wdata_ff;

endmodule // local_to_vme_map_decoders

/* File: dv/map_dec_checker.sv */
// Port timing assertions for the map decoders
`timescale 1ns/1ps

module map_dec_checker (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Handshakes
	input wire logic        reg_sel,
	input wire logic        reg_ack,
	input wire logic        acc_req,
	input wire logic        acc_claim,
	input wire logic        acc_ack,
	// VME cycle
	input wire logic        vme_req,
	input wire logic        vme_write,
	input wire logic [31:0] vme_addr,
	input wire logic [5:0]  vme_am,
	input wire logic        vme_narrow_width_select,
	input wire logic        vme_done
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_reg_answer: assert property (reg_sel && !reg_ack |=> reg_ack)
		else $error("register access not answered");
	chk_reg_pulse: assert property (reg_ack |=> !reg_ack)
		else $error("register ack too long");
	chk_idle_claim: assert property (!acc_req |-> !acc_claim)
		else $error("claim without request");
	chk_vme_launch: assert property (acc_req && acc_claim && !vme_req && !acc_ack
		|=> vme_req) else $error("claimed access not launched");
	chk_vme_hold: assert property (vme_req && !vme_done |=> vme_req)
		else $error("vme cycle dropped early");
	chk_vme_end: assert property (vme_req && vme_done |=> !vme_req)
		else $error("vme cycle not ended");
	chk_attr_steady: assert property (vme_req && $past(vme_req)
		|-> $stable({vme_am, vme_narrow_width_select, vme_addr}))
		else $error("vme cycle attributes moved");
	chk_ack_cause: assert property (acc_ack
		|-> $past(vme_req && vme_done) || ($rose(vme_req) && vme_write))
		else $error("access ack without cause");
	chk_acc_pulse: assert property (acc_ack |=> !acc_ack)
		else $error("access ack too long");

	cover property ($rose(vme_req) && vme_write && acc_ack);
	cover property (vme_req && vme_done && !vme_write);
	cover property ((acc_req && !acc_claim) [*4]);
endmodule // map_dec_checker

bind local_to_vme_map_decoders map_dec_checker u_chk (
	.mclk(mclk), .rst(rst), .reg_sel(reg_sel), .reg_ack(reg_ack), .acc_req(acc_req),
	.acc_claim(acc_claim), .acc_ack(acc_ack), .vme_req(vme_req), .vme_write(vme_write),
	.vme_addr(vme_addr), .vme_am(vme_am), .vme_done(vme_done),
	.vme_narrow_width_select(vme_narrow_width_select));

/* File: dv/vme_slave_model.sv */
// Behavioural VMEbus slave answering the bridge's master cycles
`timescale 1ns/1ps

module vme_slave_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Master cycle and answer delay
	input  wire logic        vme_req,
	input  wire logic [31:0] vme_addr,
	input  wire logic [3:0]  wait_n,
	// Answer
	output logic             vme_done,
	output logic [31:0]      vme_rdata
);
	logic [3:0] cnt_ff;

	// Read data is the inverted address; between answers the data toggles
	always @(negedge mclk or posedge rst) begin
		if (rst) begin
			{vme_done, vme_rdata, cnt_ff} <= '0;
		end else begin
			vme_done <= 1'b0;
			vme_rdata <= ~vme_rdata;
			cnt_ff <= vme_req ? cnt_ff + 4'h1 : 4'h0;
			if (vme_req && !vme_done && cnt_ff >= wait_n) begin
				vme_done <= 1'b1;
				vme_rdata <= ~vme_addr;
			end
		end
	end
endmodule // vme_slave_model

/* File: dv/tb_top.sv */
// Self-checking bench for the local-to-VME map decoders
`timescale 1ns/1ps
`include "map_dec_consts.svh"

module tb_top;
	logic        mclk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, reg_ack;
	logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, img [7];
	logic [3:0]  reg_be = '0, wait_n = '0;
	logic        acc_req = 1'b0, acc_write = 1'b0, acc_claim, acc_ack;
	logic [31:0] acc_addr = '0, acc_wdata = '0, acc_rdata, vme_addr, vme_wdata, vme_rdata;
	logic        vme_req, vme_write, vme_narrow_width_select, vme_done, vme_seen_ff = 1'b0;
	logic [5:0]  vme_am;
	logic [5:0]  am_ok [6] = '{6'h09, 6'h0d, 6'h29, 6'h2d, 6'h39, 6'h3d};
	logic [71:0] q_vme [$];
	logic [31:0] q_rd [$];
	int          n_mismatch = 0, checks = 0, seed = 35952;
	wire  [71:0] vme_got = {vme_addr, vme_am, vme_narrow_width_select, vme_write, vme_wdata};

	always #10 mclk = ~mclk;

	local_to_vme_map_decoders u_dut (
		.mclk(mclk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_be(reg_be), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_claim(acc_claim), .acc_ack(acc_ack), .acc_rdata(acc_rdata), .vme_req(vme_req),
		.vme_write(vme_write), .vme_addr(vme_addr), .vme_am(vme_am), .vme_wdata(vme_wdata),
		.vme_narrow_width_select(vme_narrow_width_select), .vme_done(vme_done),
		.vme_rdata(vme_rdata));

	vme_slave_model u_vme (.mclk(mclk), .rst(rst), .vme_req(vme_req), .vme_addr(vme_addr),
		.wait_n(wait_n), .vme_done(vme_done), .vme_rdata(vme_rdata));

	task automatic note(input logic ok, input string what);
		checks++;
		if (!ok) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic cmp_rd(input logic [31:0] got, exp);
		note(got === exp, $sformatf("read data %h expected %h", got, exp));
	endtask

	task automatic cmp_vme(input logic [71:0] got, exp);
		note(got === exp, $sformatf("vme cycle %h expected %h", got, exp));
	endtask

	task automatic cmp_flag(input logic [2:0] got, exp);
		note(got === exp, $sformatf("flags %b expected %b", got, exp));
	endtask

	task automatic wrap_up;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic reg_io(input logic wr, input logic [31:0] a, d, input logic [3:0] be);
		int          i;
		logic [31:0] m;
		i = (a - `MD_ADDR_SEG1) >> 2;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & ((i == 6) ? 32'h000f_0000 : '1);
		if (i < 7 && wr) img[i] = (img[i] & ~m) | (d & m);
		if (!wr) q_rd.push_back((i < 7) ? img[i] : '0);
		@(negedge mclk);
		{reg_sel, reg_wr, reg_addr, reg_wdata, reg_be} <= {1'b1, wr, a, d, be};
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		reg_sel <= 1'b0;
	endtask

	// Segment zero means no decoder may claim the access
	task automatic acc_io(input logic wr, input logic [31:0] a, input int seg);
		logic [7:0]  at;
		logic [15:0] hi;
		logic [31:0] wd;
		logic        busy;
		int          n;
		at = img[5] >> (8 * seg - 8);
		hi = (seg == 4) ? (img[4][31:16] & img[4][15:0]) | (a[31:16] & ~img[4][15:0]) : a[31:16];
		wd = $random(seed);
		@(negedge mclk);
		while (seg == 0 && vme_req) @(negedge mclk);
		busy = vme_req;
		wait_n <= 4'($random(seed));
		{acc_req, acc_write, acc_addr, acc_wdata} <= {1'b1, wr, a, wd};
		if (seg == 0) begin
			repeat (4) @(posedge mclk);
			cmp_flag({acc_claim, acc_ack, vme_req}, 3'b000);
		end else begin
			q_vme.push_back({hi, a[15:0], at[5:0], at[7], wr, wd});
			if (!wr) q_rd.push_back(~{hi, a[15:0]});
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (!acc_ack && n < 40);
			// From idle a posted write acks at the second edge, any other access later
			cmp_flag({acc_claim, acc_ack, busy || ((n == 2) == (wr && at[6]))}, 3'b111);
		end
		@(negedge mclk);
		acc_req <= 1'b0;
	endtask

	always @(posedge mclk) begin
		vme_seen_ff <= vme_req;
		if (reg_ack && !reg_wr)
			cmp_rd(reg_rdata, q_rd.pop_front());
		if (acc_ack && !acc_write)
			cmp_rd(acc_rdata, q_rd.pop_front());
		if (vme_req && !vme_seen_ff)
			cmp_vme(vme_got, q_vme.pop_front());
	end

	initial begin
		logic [31:0] at;
		logic [3:0]  en;
		foreach (img[i]) img[i] = '0;
		repeat (10) @(negedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) reg_io(1'b0, `MD_ADDR_SEG1 + 4 * i, '0, '0);
		for (int i = 0; i < 8; i++) reg_io(1'b1, `MD_ADDR_SEG1 + 4 * i, $random(seed), $random(seed));
		for (int i = 0; i < 8; i++) reg_io(1'b0, `MD_ADDR_SEG1 + 4 * i, '0, '0);
		for (int s = 1; s < 5; s++) reg_io(1'b1, `MD_ADDR_SEG1 + 4 * s - 4, {4'(s), 12'h0ff, 4'(s), 12'h000}, 4'hf);
		reg_io(1'b1, `MD_ADDR_XLATE4, $random(seed), 4'hf);
		for (int r = 0; r < 6; r++) begin
			en = (r == 5) ? 4'h5 : 4'hf;
			for (int b = 0; b < 4; b++) at[8 * b +: 8] = {2'($random(seed)), am_ok[(r + b) % 6]};
			reg_io(1'b1, `MD_ADDR_ATTR, at, 4'hf);
			reg_io(1'b1, `MD_ADDR_ENABLE, {12'h000, en, 16'h0000}, 4'hf);
			for (int s = 1; s < 5; s++) begin
				acc_io(r[0], {4'(s), 12'h000, 16'($random(seed))}, en[s - 1] ? s : 0);
				acc_io(!r[0], {4'(s), 12'h0ff, 16'($random(seed))}, en[s - 1] ? s : 0);
				acc_io(1'b0, {4'(s), 12'h100, 16'h0000}, 0);
			end
		end
		repeat (20) @(posedge mclk);
		// Reset in mid-run must clear every programmed word again
		@(negedge mclk);
		rst <= 1'b1;
		repeat (2) @(negedge mclk);
		rst <= 1'b0;
		foreach (img[i]) img[i] = '0;
		for (int i = 0; i < 8; i++) reg_io(1'b0, `MD_ADDR_SEG1 + 4 * i, '0, '0);
		repeat (4) @(posedge mclk);
		cmp_flag({1'b0, q_rd.size() == 0, q_vme.size() == 0}, 3'b011);
		wrap_up;
	end

	initial begin
		#200us;
		n_mismatch++;
		wrap_up;
	end
endmodule // tb_top
